// ---- rtl/oss_serial_ctrl.sv ----
// Purpose: Serial command/status control of an eight-output low-side switch
// Assumes: sclk_i is the link clock, cs_n_i framing; faults arrive as levels
// Notes:   Output latch and fault latches live on clk_i; frame events cross
//          by toggles. Status capture happens in the link domain itself.
`timescale 1ns/1ps
`default_nettype none
module oss_serial_ctrl
  import oss_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          sclk_i,
  input  wire logic          cs_n_i,
  input  wire logic          si_i,
  output logic               so_o,
  output logic               so_oe_o,
  input  wire logic          rst_n_i,
  input  wire logic          short_protect_disable_i,
  input  wire logic          load_supply_ov_i,
  input  wire oss_fault_type fault_i,
  input  wire logic [7:0]    drain_high_i,
  output logic [7:0]         out_off_o,
  output logic [7:0]         limit_mode_o
);

  // ----------------------------------------------------------------
  // Link domain: shift register on the serial clock
  // ----------------------------------------------------------------
  logic [7:0] shift_reg;
  logic [7:0] status_snap;
  logic [7:0] status_word;
  logic       so_reg;
  logic       rise_tog_reg;
  logic [3:0] bit_cnt_reg;

  // Next shift content: the first falling edge of a frame starts from the
  // status snapshot, so the word captured at select fall leaves first.
  function automatic logic [7:0] oss_shift_next(input logic [3:0] cnt,
                                                input logic [7:0] snap,
                                                input logic [7:0] cur,
                                                input logic       din);
    if (cnt == 4'h0) begin
      return {snap[6:0], din};
    end
    return {cur[6:0], din};
  endfunction

  // Counts falling edges in a frame. Select high clears it at once, because
  // the serial clock may stay parked low between frames and give no edge then.
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg <= 4'h0;
    end else if (bit_cnt_reg != 4'h8) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Output shifts on rising clock, MSB first; extra clocks pass on old bits
  always_ff @(posedge sclk_i) begin
    if (!cs_n_i) begin
      if (bit_cnt_reg == 4'h0) begin
        so_reg <= status_snap[7];
      end else begin
        so_reg <= shift_reg[7];
      end
    end
  end

  // Sample on falling clock; the first edge folds in the status snapshot
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= OSS_SHIFT_RST;
    end else if (!cs_n_i) begin
      shift_reg <= oss_shift_next(bit_cnt_reg, status_snap, shift_reg, si_i);
    end
  end

  // Status snapshot at select fall. The status word moves only a few clk_i
  // cycles after a latch transfer or fault change, so a frame started well
  // after those sees a steady word; a fault edge right at the capture can
  // give a mixed word for that one frame.
  always_ff @(negedge cs_n_i) begin
    status_snap <= status_word;
  end

  // Toggle per select rise. The reset pin parks it at a known level so the
  // crossing never carries an unknown; a toggle caused by that reset lands
  // while the synchronised reset already holds the latch.
  always_ff @(posedge cs_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_tog_reg <= 1'b0;
    end else begin
      rise_tog_reg <= ~rise_tog_reg;
    end
  end

  // Driver follows select only, not the reset pin
  assign so_oe_o = ~cs_n_i;
  assign so_o    = cs_n_i ? 1'b0 : so_reg;

  // ----------------------------------------------------------------
  // System domain: synchronisers
  // ----------------------------------------------------------------
  logic rst_n_s;
  logic short_protect_disable_s;
  logic ov_s;
  logic rise_pulse;
  logic [7:0] short_s;
  logic [7:0] therm_s;
  logic [7:0] open_s;
  logic [7:0] drain_s;

  oss_sync2 u_rst (.clk_i (clk_i), .d_i (rst_n_i), .q_o (rst_n_s));
  oss_sync2 u_short_protect_disable (.clk_i (clk_i), .d_i (short_protect_disable_i), .q_o (short_protect_disable_s));
  oss_sync2 u_ov (.clk_i (clk_i), .d_i (load_supply_ov_i), .q_o (ov_s));

  genvar g;
  generate
    for (g = 0; g < OSS_WIDTH; g++) begin : g_sync
      oss_sync2 u_sh (.clk_i (clk_i), .d_i (fault_i.short_flt[g]), .q_o (short_s[g]));
      oss_sync2 u_th (.clk_i (clk_i), .d_i (fault_i.therm_flt[g]), .q_o (therm_s[g]));
      oss_sync2 u_op (.clk_i (clk_i), .d_i (fault_i.open_flt[g]), .q_o (open_s[g]));
      oss_sync2 u_dr (.clk_i (clk_i), .d_i (drain_high_i[g]), .q_o (drain_s[g]));
    end
  endgenerate

  oss_toggle_sync u_rise (
    .clk_i    (clk_i),
    .toggle_i (rise_tog_reg),
    .pulse_o  (rise_pulse)
  );

  // ----------------------------------------------------------------
  // Output latch and protection
  // ----------------------------------------------------------------
  logic [7:0] cmd_reg;
  logic [7:0] trip_reg;
  logic       ov_lock_reg;

  // Status bit: high when off, low when on; open flips it, short flips it only when on
  function automatic logic [7:0] oss_status_bits(input logic [7:0] off,
                                                 input logic [7:0] open,
                                                 input logic [7:0] short);
    return off ^ open ^ (short & ~off);
  endfunction

  // Shift register is stable while select is high, so reading it here
  // after the toggle crossing is safe.
  always_ff @(posedge clk_i) begin
    if (rst_i || !rst_n_s) begin
      cmd_reg <= OSS_ALL_OFF;
    end else if (rise_pulse) begin
      cmd_reg <= shift_reg;
    end
  end

  // Latched short trip only when protection enabled; cleared by new command
  always_ff @(posedge clk_i) begin
    if (rst_i || !rst_n_s) begin
      trip_reg <= 8'h00;
    end else if (!short_protect_disable_s) begin
      trip_reg <= (rise_pulse ? 8'h00 : trip_reg) | (short_s & ~cmd_reg);
    end else if (rise_pulse) begin
      trip_reg <= 8'h00;
    end
  end

  // Over-voltage shuts all off until next command transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_lock_reg <= 1'b0;
    end else if (ov_s) begin
      ov_lock_reg <= 1'b1;
    end else if (rise_pulse) begin
      ov_lock_reg <= 1'b0;
    end
  end

  logic [7:0] off_next;
  always_comb begin
    off_next = cmd_reg | trip_reg | therm_s;
    if (ov_lock_reg || ov_s) begin
      off_next = OSS_ALL_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_off_o    <= OSS_ALL_OFF;
      limit_mode_o <= 8'h00;
    end else begin
      out_off_o    <= off_next;
      limit_mode_o <= short_protect_disable_s ? (short_s & ~off_next) : 8'h00;
    end
  end

  // Status: high when off, low when on, all high under over-voltage; open faults flip bits, shorts flip only bits of outputs that are on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_word <= OSS_ALL_OFF;
    end else if (ov_lock_reg || ov_s) begin
      status_word <= OSS_ALL_OFF;
    end else begin
      status_word <= oss_status_bits(out_off_o, open_s, short_s);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // System-domain checks first; the link-domain ones below are held off
  // while select is high, when the serial clock may run for nothing.
  a_oe_follows_cs: assert property (
    @(posedge clk_i) disable iff (rst_i)
    so_oe_o == !cs_n_i)
    else $error("Status driver not tied to select");

  a_ov_all_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ov_s |=> out_off_o == 8'hff)
    else $error("Over-voltage left an output on");

  a_ov_lock_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ov_s |=> ov_lock_reg)
    else $error("Over-voltage lock not set");

  a_reset_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rst_n_s |=> ##1 out_off_o == 8'hff)
    else $error("Reset left an output on");

  a_latch_xfer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rise_pulse && rst_n_s |=> cmd_reg == $past(shift_reg))
    else $error("Latch missed");

  a_latch_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ov_s && !ov_lock_reg && trip_reg == 8'h00 && therm_s == 8'h00
    |=> out_off_o == $past(cmd_reg))
    else $error("Outputs differ from latch");

  a_short_trip: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !short_protect_disable_s && (short_s & ~cmd_reg) != 8'h00 && rst_n_s && !rise_pulse
    |=> ##1 (out_off_o & $past(short_s, 2)) == $past(short_s, 2))
    else $error("Short did not trip output");

  a_trip_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !short_protect_disable_s && !rise_pulse && rst_n_s |=> (trip_reg & $past(trip_reg)) == $past(trip_reg))
    else $error("Short trip dropped early");

  a_trip_clear_spd: assert property (
    @(posedge clk_i) disable iff (rst_i)
    short_protect_disable_s && rise_pulse && rst_n_s |=> trip_reg == 8'h00)
    else $error("Trip kept with protection off");

  a_therm_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    therm_s != 8'h00 |=> (out_off_o & $past(therm_s)) == $past(therm_s))
    else $error("Hot output left on");

  a_limit_on: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (limit_mode_o & out_off_o) == 8'h00)
    else $error("Limited output shown off");

  a_lim_from_spd: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !short_protect_disable_s |=> limit_mode_o == 8'h00)
    else $error("Limit mode with protection on");

  a_lim_needs_short: assert property (
    @(posedge clk_i) disable iff (rst_i)
    limit_mode_o != 8'h00 |-> ($past(short_s) & limit_mode_o) == limit_mode_o)
    else $error("Limit mode without a short");

  a_status_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ov_lock_reg |=> status_word == 8'hff)
    else $error("Status not all ones");

  a_status_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ov_lock_reg && !ov_s && open_s == 8'h00 && short_s == 8'h00
    |=> status_word == $past(out_off_o))
    else $error("Status differs from outputs");

  a_cmd_stable: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rise_pulse && rst_n_s |=> cmd_reg == $past(cmd_reg))
    else $error("Latch moved");

  // Link-domain checks on the serial clock
  a_so_first: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    bit_cnt_reg == 4'h0 |=> so_reg == $past(status_snap[7]))
    else $error("First status bit wrong");

  a_so_pass_on: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    bit_cnt_reg != 4'h0 |=> so_reg == $past(shift_reg[7]))
    else $error("Status shift out wrong");

  a_cnt_sat: assert property (
    @(negedge sclk_i) disable iff (cs_n_i)
    bit_cnt_reg <= 4'h8)
    else $error("Bit counter ran past eight");
endmodule
`default_nettype wire

// ---- pkg/oss_pkg.sv ----
// Purpose: Shared constants and types for the octal switch serial control block
// Assumes: 8 outputs, 8-bit frames, system clock 40 MHz
// Notes:   Output latch bit 1 means off, matching the command polarity
`default_nettype none
package oss_pkg;
  localparam int          OSS_WIDTH       = 8;
  localparam logic [7:0]  OSS_ALL_OFF     = 8'hff;
  localparam logic [7:0]  OSS_SHIFT_RST   = 8'h00;
  localparam int          OSS_CLK_PERIOD_PS = 25000;
  localparam int          OSS_RST_MIN_PS  = 250000;
  localparam int          OSS_RST_CYCLES  =
    (OSS_RST_MIN_PS + OSS_CLK_PERIOD_PS - 1) / OSS_CLK_PERIOD_PS;

  // Per-output fault indications from the analog side
  typedef struct packed {
    logic [7:0] short_flt;
    logic [7:0] open_flt;
    logic [7:0] therm_flt;
  } oss_fault_type;
endpackage
`default_nettype wire

// ---- rtl/oss_sync2.sv ----
// Purpose: Two-flop level synchroniser
// Assumes: Input is asynchronous to clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module oss_sync2 (
  input  wire logic clk_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_reg;
  logic q_reg;

  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_reg    <= meta_reg;
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

// ---- rtl/oss_toggle_sync.sv ----
// Purpose: Carry a one-cycle event from the link domain into clk_i
// Assumes: Events are spaced by several clk_i cycles
// Notes:   Toggle in, edge out; the output pulse lasts one clk_i cycle
`timescale 1ns/1ps
`default_nettype none
module oss_toggle_sync (
  input  wire logic clk_i,
  input  wire logic toggle_i,
  output logic      pulse_o
);
  logic sync_q;
  logic last_reg;

  oss_sync2 u_sync (
    .clk_i (clk_i),
    .d_i   (toggle_i),
    .q_o   (sync_q)
  );

  always_ff @(posedge clk_i) begin
    last_reg <= sync_q;
  end

  assign pulse_o = sync_q ^ last_reg;
endmodule
`default_nettype wire

// ---- verif/oss_spi_master.sv ----
// Purpose: Serial master model driving command frames into the switch
// Assumes: Clock idles low and runs inside frames, and also while deselected in noise
// Notes:   Status is read just before each falling clock edge
`timescale 1ns/1ps
`default_nettype none
module oss_spi_master (
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic       si_o,
  output logic       done_o,
  output logic [7:0] status_o,
  input  wire logic  so_i,
  input  wire logic  so_oe_i
);
  localparam time HALF = 24ns;
  logic line_last = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    done_o = 1'b0;
    status_o = 8'h00;
  end
  task automatic shift_byte(input logic [7:0] d, output logic [7:0] s);
    for (int i = 7; i >= 0; i--) begin
      // Data moves mid low phase, clear of both clock edges
      #(HALF/2) si_o = d[i];                    // Output 7 first
      #(HALF/2) sclk_o = 1'b1;
      #HALF;
      // Undriven line shows the inverse of its last level
      line_last = so_oe_i ? so_i : ~line_last;
      s[i] = line_last;
      sclk_o = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input bit two);
    logic [7:0] s;
    #7 cs_n_o = 1'b0;                           // Clock is low here
    #HALF shift_byte(a, s);
    if (two) shift_byte(b, s);
    #HALF si_o = ~si_o;
    cs_n_o = 1'b1;
    status_o = s;
    done_o = ~done_o;
  endtask
  // Deliberate activity while deselected
  task automatic noise();
    repeat (4) begin
      #HALF sclk_o = 1'b1;
      si_o = ~si_o;
      #HALF sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/test_octal_switch_serial_control.sv ----
// Purpose: Self-checking bench for the switch serial control
// Assumes: Open and thermal faults stay clear
// Notes:   Expected status tracks the last applied command word, or the first byte of a two-byte frame
`timescale 1ns/1ps
`default_nettype none
module test_octal_switch_serial_control;
  import oss_pkg::*;
  logic          clk_i;
  logic          rst_i = 1'b1;
  logic          rst_n = 1'b0;
  logic          spd = 1'b0;
  logic          ov = 1'b0;
  oss_fault_type flt = '0;
  logic [7:0]    drain = 8'h00;
  wire logic     sclk, cs_n, si, so, so_oe, done;
  wire logic [7:0] status, off, lim;
  int            n_errors = 0;
  int            n_compared = 0;
  logic [7:0]    exp_status[$];
  logic [7:0]    exp_off[$];
  logic [7:0]    cur_off = OSS_ALL_OFF;

  oss_serial_ctrl oss_serial_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .rst_n_i(rst_n),
    .short_protect_disable_i(spd), .load_supply_ov_i(ov), .fault_i(flt),
    .drain_high_i(drain), .out_off_o(off), .limit_mode_o(lim));
  oss_spi_master oss_spi_master_inst (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
    .done_o(done), .status_o(status), .so_i(so), .so_oe_i(so_oe));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic send(input logic [7:0] a, input logic [7:0] b, input bit two);
    exp_status.push_back(two ? a : cur_off);
    exp_off.push_back(two ? b : a);
    cur_off = two ? b : a;
    oss_spi_master_inst.frame(a, b, two);
    tick(12);
  endtask
  // ----------------------------------------------------------------
  // Watcher
  // ----------------------------------------------------------------
  always @(done) begin
    if (exp_status.size() > 0) begin
      check(status, exp_status.pop_front());
      repeat (8) @(posedge clk_i);
      check(off, exp_off.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h9fca));
    tick(16);
    rst_i = 1'b0;
    rst_n = 1'b1;
    tick(4);
    check(off, OSS_ALL_OFF);
    send(8'h00, 8'h00, 1'b0);
    send(8'hff, 8'h00, 1'b0);
    send(8'h5a, 8'h00, 1'b0);
    send(8'h5a, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      drain = 8'($urandom());
      send(8'($urandom()), 8'h00, 1'b0);
    end
    send(8'h3c, 8'ha5, 1'b1);
    oss_spi_master_inst.noise();
    tick(8);
    check(off, cur_off);
    check({7'h00, so_oe}, 8'h00);
    send(8'h00, 8'h00, 1'b0);
    rst_n = 1'b0;                  // Held 12 cycles, above 250 ns
    tick(12);
    check(off, OSS_ALL_OFF);
    rst_n = 1'b1;
    cur_off = OSS_ALL_OFF;
    send(8'h00, 8'h00, 1'b0);
    ov = 1'b1;
    tick(8);
    check(off, OSS_ALL_OFF);
    ov = 1'b0;
    cur_off = OSS_ALL_OFF;
    send(8'h0f, 8'h00, 1'b0);
    send(8'h00, 8'h00, 1'b0);
    flt.short_flt = 8'h04;
    tick(8);
    check(off, 8'h04);
    flt.short_flt = 8'h00;
    cur_off = 8'h04;
    spd = 1'b1;
    send(8'h00, 8'h00, 1'b0);
    flt.short_flt = 8'h10;
    tick(8);
    check(off, 8'h00);
    check(lim, 8'h10);
    flt.short_flt = 8'h00;
    tick(8);
    check(off, 8'h00);
    spd = 1'b0;
    send(8'($urandom()), 8'h00, 1'b0);
    tick(20);
    final_report();
  end
endmodule
`default_nettype wire
